/* hw/uzp_pkg.sv */
// package: constants and types shared by the underimpedance stage logic
package uzp_pkg;

  // clock and time base
  localparam int CLK_KHZ      = 40000;                  // pclk rate in kHz
  localparam int TS_RES_MS    = 1;                      // timestamp resolution
  localparam int MS_CYC_DEF   = TS_RES_MS * CLK_KHZ;    // pclk cycles per timestamp step
  localparam int PROG_MS      = 5;                      // program cycle length
  localparam int PRE_TRIG_MS  = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int PRE_TRIG_N   = PRE_TRIG_MS / PROG_MS;  // history taps
  localparam int PRE_FAULT_N  = PRE_FAULT_MS / PROG_MS;
  localparam int NSTG         = 2;
  localparam int NREC         = 12;

  // comparator constants
  localparam logic [7:0]  PCT_FULL = 8'h64;             // 100 percent
  localparam logic [7:0]  HYST_PCT = 8'h67;             // 103 percent release ratio
  localparam logic [15:0] SET_RST  = 16'h03e8;          // 10.00 ohm in 0.01 ohm steps
  localparam logic [15:0] DLY_RST  = 16'h0014;          // 20 program cycles
  localparam logic [3:0]  EVM_RST  = 4'hf;              // on and off events reported, both stages
  localparam logic [1:0]  MODE_PE  = 2'h1;
  localparam logic [1:0]  MODE_PP  = 2'h2;
  localparam logic [1:0]  MODE_POS = 2'h3;

  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SET0   = 8'h04;
  localparam logic [7:0] A_SET1   = 8'h08;
  localparam logic [7:0] A_DLY0   = 8'h0c;
  localparam logic [7:0] A_DLY1   = 8'h10;
  localparam logic [7:0] A_EVM    = 8'h14;
  localparam logic [7:0] A_STAT   = 8'h18;
  localparam logic [7:0] A_REM0   = 8'h1c;
  localparam logic [7:0] A_REM1   = 8'h20;
  localparam logic [7:0] A_RAT0   = 8'h24;
  localparam logic [7:0] A_RAT1   = 8'h28;
  localparam logic [7:0] A_CNT0   = 8'h2c;
  localparam logic [7:0] A_CNT1   = 8'h30;
  localparam logic [7:0] A_RSEL   = 8'h34;
  localparam logic [7:0] A_REC0   = 8'h38;
  localparam logic [7:0] A_REC1   = 8'h3c;
  localparam logic [7:0] A_REC2   = 8'h40;
  localparam logic [7:0] A_REC3   = 8'h44;
  localparam logic [7:0] A_RCNT   = 8'h48;

  // control register fields
  localparam int C_MODE    = 0;                         // two bits
  localparam int C_FRC_EN  = 2;
  localparam int C_FRC_B   = 3;                         // two bits, one per stage
  localparam int C_CNT_CLR = 5;                         // write one to clear counters
  localparam int C_INST    = 6;                         // two bits, instant mode per stage
  localparam logic [1:0] MODE_RST = MODE_PE;

  typedef enum logic [1:0] {
    ST_NORMAL  = 2'b00,
    ST_START   = 2'b01,
    ST_TRIP    = 2'b10,
    ST_BLOCKED = 2'b11
  } uzp_cond_t;

endpackage

/* hw/uzp_zhist.sv */
// impedance history line, one sample per program cycle
`timescale 1ns/10ps
`default_nettype none
module uzp_zhist
  import uzp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        shift,
  input  wire logic [15:0] din,
  output logic      [15:0] tap_trig,
  output logic      [15:0] tap_fault
);

  logic [15:0] mem_q [PRE_FAULT_N];

  // shift in the newest sample, oldest falls off the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PRE_FAULT_N; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (shift) begin
      mem_q[0] <= din;
      for (int i = 1; i < PRE_FAULT_N; i++) begin
        mem_q[i] <= mem_q[i-1];
      end
    end
  end

  // taps read before the shift of the same edge
  assign tap_trig  = mem_q[PRE_TRIG_N-1];
  assign tap_fault = mem_q[PRE_FAULT_N-1];

endmodule
`default_nettype wire

/* hw/uzp_recbuf.sv */
// circular store of the most recent operation records
`timescale 1ns/10ps
`default_nettype none
module uzp_recbuf
  import uzp_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         wr,
  input  wire logic [127:0] wdata,
  input  wire logic [3:0]   rd_sel,
  output logic      [127:0] rdata,
  output logic      [3:0]   count
);

  logic [127:0] mem_q [NREC];
  logic [3:0]   wptr_q;
  logic [3:0]   cnt_q;
  logic [3:0]   rd_idx;

  // age 0 is the newest entry
  function automatic logic [3:0] age_idx(input logic [3:0] wp, input logic [3:0] age);
    logic [4:0] s;
    s = {1'b0, wp} + 5'(NREC) - 5'h01 - {1'b0, age};
    if (s >= 5'(NREC)) begin
      s = s - 5'(NREC);
    end
    return s[3:0];
  endfunction

  // write pointer wraps, oldest entry is overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= 4'h0;
      cnt_q  <= 4'h0;
    end else if (wr) begin
      wptr_q <= (wptr_q == 4'(NREC - 1)) ? 4'h0 : wptr_q + 4'h1;
      cnt_q  <= (cnt_q == 4'(NREC)) ? cnt_q : cnt_q + 4'h1;
    end
  end

  // entry storage, no reset needed
  always_ff @(posedge pclk) begin
    if (wr) begin
      mem_q[wptr_q] <= wdata;
    end
  end

  assign rd_idx = age_idx(wptr_q, (rd_sel >= 4'(NREC)) ? 4'h0 : rd_sel);
  assign rdata  = (rd_sel < cnt_q) ? mem_q[rd_idx] : 128'h0;
  assign count  = cnt_q;

endmodule
`default_nettype wire

/* hw/uzp_stage_logic.sv */
// underimpedance two-stage protection logic with apb registers
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module uzp_stage_logic
  import uzp_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] z_pe1,
  input  wire logic [15:0] z_pe2,
  input  wire logic [15:0] z_pe3,
  input  wire logic [15:0] z_pp12,
  input  wire logic [15:0] z_pp23,
  input  wire logic [15:0] z_pp31,
  input  wire logic [15:0] z_pos,
  input  wire logic [2:0]  setting_group,
  input  wire logic [1:0]  blk_pin,
  output logic      [1:0]  stage_start,
  output logic      [1:0]  stage_trip,
  output logic      [1:0]  stage_blocked,
  output logic             blk_notify,
  output logic             evt_valid,
  output logic      [3:0]  evt_code,
  output logic      [31:0] evt_stamp,
  output logic      [15:0] evt_z
);

  function automatic logic [15:0] min3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m = (a < b) ? a : b;
    return (m < c) ? m : c;
  endfunction

  // measured impedance over setting, hundredths, saturated
  function automatic logic [15:0] ratio_f(input logic [15:0] z, input logic [15:0] s);
    logic [23:0] q;
    q = (24'(z) * 24'(PCT_FULL)) / 24'((s == 16'h0) ? 16'h0001 : s);
    return (q > 24'h00ffff) ? 16'hffff : q[15:0];
  endfunction

  function automatic logic [3:0] first_f(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // registers and state
  logic [1:0]  mode_q;
  logic        frc_en_q;
  logic [1:0]  frc_b_q;
  logic [1:0]  inst_q;
  logic [3:0]  evm_q;
  logic [3:0]  rsel_q;
  logic [15:0] set_q [NSTG];
  logic [15:0] dly_q [NSTG];
  logic [31:0] prdata_q;
  logic [31:0] ms_cnt_q;
  logic [2:0]  phase_q;
  logic [31:0] stamp_q;
  logic [1:0]  blk_m_q;
  logic [1:0]  blk_s_q;
  uzp_cond_t   st_q [NSTG];
  uzp_cond_t   st_d [NSTG];
  logic [1:0]  pick_q;
  logic [15:0] tmr_q [NSTG];
  logic [15:0] tmr_d [NSTG];
  logic [7:0]  cnt_q [NSTG][3];
  logic [15:0] pend_q;
  logic [31:0] snap_stamp_q;
  logic [15:0] snap_z_q;
  logic [15:0] snap_p20_q;
  logic [15:0] snap_p200_q;
  logic [2:0]  snap_sg_q;
  logic [2:0]  snap_flt_q [NSTG];
  logic [15:0] snap_rem_q [NSTG];
  logic        evt_valid_q;
  logic [3:0]  evt_code_q;
  logic [31:0] evt_stamp_q;
  logic [15:0] evt_z_q;

  // wires
  logic        ms_tick;
  logic        prog_tick;
  logic [15:0] z_min;
  logic [15:0] z_h20;
  logic [15:0] z_h200;
  logic [1:0]  below;
  logic [1:0]  rel_ok;
  logic [1:0]  pick_d;
  logic [1:0]  blk_eff;
  logic [15:0] rem [NSTG];
  logic [15:0] ratio [NSTG];
  logic [2:0]  flt [NSTG];
  logic [15:0] ev_new;
  logic [3:0]  ev_idx;
  logic        ev_any;
  logic        ev_keep;
  logic        rec_wr;
  logic [127:0] rec_wdata;
  logic [127:0] rec_rdata;
  logic [3:0]  rec_cnt;
  logic        wr_en;
  logic        cnt_clr;
  logic        hit;
  logic [31:0] rd_d;

  // millisecond tick, timestamp, program cycle of five steps
  assign ms_tick   = (ms_cnt_q == 32'(MS_CYC - 1));
  assign prog_tick = ms_tick && (phase_q == 3'(PROG_MS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= 32'h0;
      phase_q  <= 3'h0;
      stamp_q  <= 32'h0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
      if (ms_tick) begin
        phase_q <= (phase_q == 3'(PROG_MS - 1)) ? 3'h0 : phase_q + 3'h1;
        stamp_q <= stamp_q + 32'h1;
      end
    end
  end

  // two-flop synchroniser on the blocking inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_m_q <= 2'b00;
      blk_s_q <= 2'b00;
    end else begin
      blk_m_q <= blk_pin;
      blk_s_q <= blk_m_q;
    end
  end

  // monitored magnitude by operation mode
  assign z_min = (mode_q == MODE_PP)  ? min3(z_pp12, z_pp23, z_pp31) :
                 (mode_q == MODE_POS) ? z_pos :
                 min3(z_pe1, z_pe2, z_pe3);

  uzp_zhist u_hist (
    .pclk      (pclk),
    .presetn   (presetn),
    .shift     (prog_tick),
    .din       (z_min),
    .tap_trig  (z_h20),
    .tap_fault (z_h200)
  );

  // per stage comparator, state machine and counters
  for (genvar g = 0; g < NSTG; g++) begin : g_stg
    assign below[g]   = z_min < set_q[g];
    assign rel_ok[g]  = (24'(z_min) * 24'(PCT_FULL)) > (24'(set_q[g]) * 24'(HYST_PCT));
    assign pick_d[g]  = pick_q[g] ? ~rel_ok[g] : below[g];
    assign blk_eff[g] = frc_en_q ? frc_b_q[g] : blk_s_q[g];
    assign flt[g]     = (mode_q == MODE_PP)  ? {z_pp31 < set_q[g], z_pp23 < set_q[g],
                                                z_pp12 < set_q[g]} :
                        (mode_q == MODE_POS) ? {3{z_pos < set_q[g]}} :
                        {z_pe3 < set_q[g], z_pe2 < set_q[g], z_pe1 < set_q[g]};
    assign rem[g]     = (st_q[g] == ST_START) ? tmr_q[g] : 16'h0;
    assign ratio[g]   = ratio_f(snap_z_q, set_q[g]);
    assign tmr_d[g]   = (st_d[g] != ST_START) ? 16'h0 :
                        (st_q[g] != ST_START) ? dly_q[g] : tmr_q[g] - 16'h1;

    // next condition, evaluated once per program cycle
    always_comb begin
      st_d[g] = st_q[g];
      case (st_q[g])
        ST_NORMAL: begin
          if (pick_d[g] && blk_eff[g]) begin
            st_d[g] = ST_BLOCKED;
          end else if (pick_d[g]) begin
            st_d[g] = (inst_q[g] || dly_q[g] == 16'h0) ? ST_TRIP : ST_START;
          end
        end
        ST_START: begin
          if (!pick_d[g]) begin
            st_d[g] = ST_NORMAL;
          end else if (blk_eff[g]) begin
            st_d[g] = ST_BLOCKED;
          end else if (tmr_q[g] <= 16'h0001) begin
            st_d[g] = ST_TRIP;
          end
        end
        ST_TRIP: begin
          if (!pick_d[g]) begin
            st_d[g] = ST_NORMAL;
          end else if (blk_eff[g]) begin
            st_d[g] = ST_BLOCKED;
          end
        end
        ST_BLOCKED: begin
          if (!pick_d[g] || !blk_eff[g]) begin
            st_d[g] = ST_NORMAL;
          end
        end
        default: st_d[g] = ST_NORMAL;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q[g]   <= ST_NORMAL;
        pick_q[g] <= 1'b0;
        tmr_q[g]  <= 16'h0;
      end else if (prog_tick) begin
        st_q[g]   <= st_d[g];
        pick_q[g] <= pick_d[g];
        tmr_q[g]  <= tmr_d[g];
      end
    end

    assign stage_start[g]   = (st_q[g] == ST_START) || (st_q[g] == ST_TRIP);
    assign stage_trip[g]    = (st_q[g] == ST_TRIP);
    assign stage_blocked[g] = (st_q[g] == ST_BLOCKED);

    // rise and fall of start, trip, blocked: index {stage, kind, off}
    assign ev_new[g*8 +: 8] = prog_tick ? {2'b00,
      stage_blocked[g] & (st_d[g] != ST_BLOCKED), ~stage_blocked[g] & (st_d[g] == ST_BLOCKED),
      stage_trip[g] & (st_d[g] != ST_TRIP), ~stage_trip[g] & (st_d[g] == ST_TRIP),
      stage_start[g] & (st_d[g] == ST_NORMAL || st_d[g] == ST_BLOCKED),
      ~stage_start[g] & (st_d[g] == ST_START || st_d[g] == ST_TRIP)} : 8'h00;

    // occurrence counters, an event in a clearing cycle counts as one
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int k = 0; k < 3; k++) begin
          cnt_q[g][k] <= 8'h00;
        end
      end else begin
        for (int k = 0; k < 3; k++) begin
          if (ev_new[g*8 + k*2]) begin
            cnt_q[g][k] <= cnt_clr ? 8'h01 : cnt_q[g][k] + 8'h01;
          end else if (cnt_clr) begin
            cnt_q[g][k] <= 8'h00;
          end
        end
      end
    end
  end

  assign blk_notify = |stage_blocked;

  // pending events drain one per cycle, lowest index first
  assign ev_any    = |pend_q;
  assign ev_idx    = first_f(pend_q);
  assign ev_keep   = evm_q[{ev_idx[3], ev_idx[0]}];
  assign rec_wr    = ev_any && !ev_idx[0];
  assign rec_wdata = {16'h0, snap_p200_q, snap_z_q, snap_p20_q, snap_rem_q[ev_idx[3]], 5'h00,
                      snap_sg_q, 1'b0, snap_flt_q[ev_idx[3]], ev_idx, snap_stamp_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q      <= 16'h0;
      evt_valid_q <= 1'b0;
      evt_code_q  <= 4'h0;
      evt_stamp_q <= 32'h0;
      evt_z_q     <= 16'h0;
    end else begin
      pend_q      <= (pend_q & ~(ev_any ? (16'h0001 << ev_idx) : 16'h0)) | ev_new;
      evt_valid_q <= ev_any && ev_keep;
      evt_code_q  <= ev_idx;
      evt_stamp_q <= snap_stamp_q;
      evt_z_q     <= snap_z_q;
    end
  end

  // process data snapshot taken at each program cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_stamp_q <= 32'h0;
      snap_z_q     <= 16'h0;
      snap_p20_q   <= 16'h0;
      snap_p200_q  <= 16'h0;
      snap_sg_q    <= 3'h0;
      for (int i = 0; i < NSTG; i++) begin
        snap_flt_q[i] <= 3'h0;
        snap_rem_q[i] <= 16'h0;
      end
    end else if (prog_tick) begin
      snap_stamp_q <= stamp_q;
      snap_z_q     <= z_min;
      snap_p20_q   <= z_h20;
      snap_p200_q  <= z_h200;
      snap_sg_q    <= setting_group;
      for (int i = 0; i < NSTG; i++) begin
        snap_flt_q[i] <= flt[i];
        snap_rem_q[i] <= tmr_d[i];
      end
    end
  end

  uzp_recbuf u_rec (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (rec_wr),
    .wdata   (rec_wdata),
    .rd_sel  (rsel_q),
    .rdata   (rec_rdata),
    .count   (rec_cnt)
  );

  // apb decode and read mux
  assign wr_en   = psel && penable && pwrite;
  assign cnt_clr = wr_en && (paddr == A_CTRL) && pwdata[C_CNT_CLR];
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;

  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h0;
    case (paddr)
      A_CTRL: rd_d = {24'h0, inst_q, 1'b0, frc_b_q, frc_en_q, mode_q};
      A_SET0: rd_d = {16'h0, set_q[0]};
      A_SET1: rd_d = {16'h0, set_q[1]};
      A_DLY0: rd_d = {16'h0, dly_q[0]};
      A_DLY1: rd_d = {16'h0, dly_q[1]};
      A_EVM:  rd_d = {28'h0, evm_q};
      A_STAT: rd_d = {28'h0, st_q[1], st_q[0]};
      A_REM0: rd_d = {16'h0, rem[0]};
      A_REM1: rd_d = {16'h0, rem[1]};
      A_RAT0: rd_d = {16'h0, ratio[0]};
      A_RAT1: rd_d = {16'h0, ratio[1]};
      A_CNT0: rd_d = {8'h0, cnt_q[0][2], cnt_q[0][1], cnt_q[0][0]};
      A_CNT1: rd_d = {8'h0, cnt_q[1][2], cnt_q[1][1], cnt_q[1][0]};
      A_RSEL: rd_d = {28'h0, rsel_q};
      A_REC0: rd_d = rec_rdata[31:0];
      A_REC1: rd_d = rec_rdata[63:32];
      A_REC2: rd_d = rec_rdata[95:64];
      A_REC3: rd_d = rec_rdata[127:96];
      A_RCNT: rd_d = {28'h0, rec_cnt};
      default: hit = 1'b0;
    endcase
  end

  // register writes in the access phase, read data latched in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= MODE_RST;
      frc_en_q <= 1'b0;
      frc_b_q  <= 2'b00;
      inst_q   <= 2'b00;
      evm_q    <= EVM_RST;
      rsel_q   <= 4'h0;
      set_q[0] <= SET_RST;
      set_q[1] <= SET_RST;
      dly_q[0] <= DLY_RST;
      dly_q[1] <= DLY_RST;
      prdata_q <= 32'h0;
    end else begin
      if (psel && !penable && !pwrite) begin
        prdata_q <= rd_d;
      end
      if (wr_en) begin
        case (paddr)
          A_CTRL: begin
            mode_q   <= pwdata[C_MODE +: 2];
            frc_en_q <= pwdata[C_FRC_EN];
            frc_b_q  <= pwdata[C_FRC_B +: 2];
            inst_q   <= pwdata[C_INST +: 2];
          end
          A_SET0: set_q[0] <= pwdata[15:0];
          A_SET1: set_q[1] <= pwdata[15:0];
          A_DLY0: dly_q[0] <= pwdata[15:0];
          A_DLY1: dly_q[1] <= pwdata[15:0];
          A_EVM:  evm_q    <= pwdata[3:0];
          A_RSEL: rsel_q   <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  assign evt_valid = evt_valid_q;
  assign evt_code  = evt_code_q;
  assign evt_stamp = evt_stamp_q;
  assign evt_z     = evt_z_q;

  // checks on stage 0, the event mask and the timestamp
  a_pick_set: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pick_q[0]) |-> $past(below[0])) else $error("pick-up without low impedance");
  a_pick_rel: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(pick_q[0]) |-> $past(rel_ok[0])) else $error("release inside hysteresis");
  a_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stage_start[0]) |-> !$past(blk_eff[0])) else $error("start while blocked");
  a_block_excl: assert property (@(posedge pclk) disable iff (!presetn)
    prog_tick && pick_d[0] && blk_eff[0] |=> stage_blocked[0]) else $error("block ignored");
  a_block_clears: assert property (@(posedge pclk) disable iff (!presetn)
    prog_tick && blk_eff[0] && st_q[0] == ST_START |=> !stage_start[0])
    else $error("start survived blocking");
  a_trip_delay: assert property (@(posedge pclk) disable iff (!presetn)
    prog_tick && st_q[0] == ST_START && tmr_q[0] == 16'h0001 && pick_d[0] && !blk_eff[0]
    |=> stage_trip[0]) else $error("trip late");
  a_trip_start: assert property (@(posedge pclk) disable iff (!presetn)
    prog_tick && st_q[0] == ST_TRIP && !pick_d[0] |=> !stage_trip[0]) else $error("trip held");
  a_evt_mask: assert property (@(posedge pclk) disable iff (!presetn)
    evt_valid |-> $past(evm_q[{ev_idx[3], ev_idx[0]}]) && $past(ev_any))
    else $error("masked event emitted");
  a_rec_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stage_start[0]) |-> ##[0:15] (rec_wr && ev_idx == 4'h0))
    else $error("start record missing");
  a_stamp_step: assert property (@(posedge pclk) disable iff (!presetn)
    ms_tick |=> stamp_q == $past(stamp_q) + 32'h1) else $error("stamp step wrong");

endmodule
`default_nettype wire

/* verif/uzp_meas_model.sv */
// model of the impedance measurement chain and the blocking source
`timescale 1ns/10ps
`default_nettype none
module uzp_meas_model (
  input  wire logic             pclk,
  input  wire logic [15:0]      z_tgt,
  input  wire logic [2:0]       z_loop,
  input  wire logic [15:0]      z_bg,
  input  wire logic [1:0]       blk_req,
  output logic      [6:0][15:0] z_o,
  output logic      [1:0]       blk_o,
  output logic      [2:0]       sg_o
);
  // one loop carries the fault level, the others a healthy level
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 7; i++) begin
      z_o[i] <= (i == z_loop) ? z_tgt : z_bg + 16'(i);
    end
    blk_o <= blk_req;
    sg_o  <= 3'h2;
  end
endmodule
`default_nettype wire

/* verif/test_uzp_stage_logic.sv */
// self-checking bench of the underimpedance stage logic
`timescale 1ns/10ps
`default_nettype none
module test_uzp_stage_logic
  import uzp_pkg::*;
;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic             blk_notify, evt_valid;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, evt_stamp, rnd, lst;
  logic [15:0]      z_tgt, z_bg, evt_z;
  logic [6:0][15:0] z;
  logic [2:0]       z_loop, sg;
  logic [1:0]       blk_req, blk, st_s, st_t, st_b;
  logic [3:0]       evt_code;
  logic [47:0]      rq[$], eq[$];
  int               error_cnt, checked, cyc;

  uzp_meas_model u_uzp_meas_model (.pclk, .z_tgt, .z_loop, .z_bg, .blk_req, .z_o(z),
    .blk_o(blk), .sg_o(sg));
  uzp_stage_logic #(.MS_CYC(8)) u_uzp_stage_logic (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .z_pe1(z[0]), .z_pe2(z[1]),
    .z_pe3(z[2]), .z_pp12(z[3]), .z_pp23(z[4]), .z_pp31(z[5]), .z_pos(z[6]),
    .setting_group(sg), .blk_pin(blk), .stage_start(st_s), .stage_trip(st_t),
    .stage_blocked(st_b), .blk_notify, .evt_valid, .evt_code, .evt_stamp, .evt_z);

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic results;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back({15'h0, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic ev(input logic [3:0] c, input logic [15:0] v);
    eq.push_back({28'h0, c, v});
  endtask

  // new fault level and blocking request, healthy loops randomised
  task automatic setz(input logic [15:0] v, input logic [1:0] b);
    rnd = xs(rnd);
    z_tgt <= v;
    blk_req <= b;
    z_bg <= 16'h044c + {6'h0, rnd[9:0]};
  endtask

  // wait for noted events, then idle so strays are seen
  task automatic drain;
    for (int i = 0; i < 600 && eq.size() != 0; i++) @(posedge pclk);
    chk(48'(eq.size()), 48'h0);
    repeat (80) @(posedge pclk);
  endtask

  // clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // result watcher and hang guard
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({15'h0, pslverr, prdata}, rq.size() ? rq.pop_front() : '1);
    if (evt_valid === 1'b1) begin
      chk({28'h0, evt_code, evt_z}, eq.size() ? eq.pop_front() : '1);
      chk(48'(evt_stamp % PROG_MS), 48'(PROG_MS - 1));
      if (evt_code == 4'ha) chk(48'(evt_stamp), 48'(lst));
      lst <= evt_stamp;
    end
    cyc++;
    if (cyc > 30000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, z_loop, blk_req} = '0;
    z_tgt = 16'h0fff;
    z_bg = 16'h0fff;
    rnd = 32'd21;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTRL, 33'h1);
    rd(A_SET0, 33'h3e8);
    rd(A_EVM, 33'hf);
    rd(8'hfc, 33'h100000000);
    apb(1'b1, A_DLY0, 32'h2);
    apb(1'b1, A_SET1, 32'h1f4);
    apb(1'b1, A_DLY1, 32'h3);
    // pick-up with delayed trip
    z_loop <= 3'h1;
    setz(16'h03e7, 2'b00);
    ev(4'h0, 16'h03e7);
    ev(4'h2, 16'h03e7);
    drain;
    chk(48'(st_t), 48'h1);
    rd(A_STAT, 33'h2);
    // inside the reset band the stage holds, above it releases
    setz(16'h0406, 2'b00);
    repeat (120) @(posedge pclk);
    chk(48'(st_s), 48'h1);
    setz(16'h0407, 2'b00);
    ev(4'h1, 16'h0407);
    ev(4'h3, 16'h0407);
    drain;
    apb(1'b1, A_DLY0, 32'h14);
    // blocked at pick-up, then unblocked
    setz(16'h0407, 2'b01);
    repeat (120) @(posedge pclk);
    setz(16'h03e7, 2'b01);
    ev(4'h4, 16'h03e7);
    drain;
    chk({45'h0, blk_notify, st_s}, 48'h4);
    setz(16'h03e7, 2'b00);
    ev(4'h5, 16'h03e7);
    ev(4'h0, 16'h03e7);
    drain;
    // blocking arrives during start
    setz(16'h03e7, 2'b01);
    ev(4'h1, 16'h03e7);
    ev(4'h4, 16'h03e7);
    drain;
    setz(16'h044c, 2'b00);
    ev(4'h5, 16'h044c);
    drain;
    // software forced blocking
    apb(1'b1, A_CTRL, 32'h0d);
    setz(16'h03e7, 2'b00);
    ev(4'h4, 16'h03e7);
    drain;
    apb(1'b1, A_CTRL, 32'h01);
    ev(4'h5, 16'h03e7);
    ev(4'h0, 16'h03e7);
    drain;
    setz(16'h044c, 2'b00);
    ev(4'h1, 16'h044c);
    drain;
    // phase-to-phase and positive sequence selection
    for (int m = 2; m < 4; m++) begin
      apb(1'b1, A_CTRL, 32'(m));
      z_loop <= (m == 2) ? 3'h4 : 3'h6;
      setz(16'h03e7, 2'b00);
      ev(4'h0, 16'h03e7);
      drain;
      setz(16'h044c, 2'b00);
      ev(4'h1, 16'h044c);
      drain;
    end
    // both stages, second one instant
    apb(1'b1, A_CTRL, 32'h81);
    z_loop <= 3'h0;
    setz(16'h0190, 2'b00);
    ev(4'h0, 16'h0190);
    ev(4'h8, 16'h0190);
    ev(4'ha, 16'h0190);
    drain;
    rd(A_REM0, 33'h12);
    rd(A_RAT1, 33'h50);
    setz(16'h044c, 2'b00);
    ev(4'h1, 16'h044c);
    ev(4'h9, 16'h044c);
    ev(4'hb, 16'h044c);
    drain;
    rd(A_CNT1, 33'h101);
    rd(A_RCNT, 33'hc);
    rd(A_REC1, 33'h21a);
    apb(1'b1, A_CTRL, 32'h21);
    rd(A_CNT1, 33'h0);
    results();
  end
endmodule
`default_nettype wire
